// File: cpst_pkg.sv
// Purpose: Shared types and constants for the CPU state and LED indicator.
// Assumes: 20 MHz system clock.
// Notes: Long cycle counts are also top-level parameters.
`default_nettype none
package cpst_pkg;
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned SLOW_HALF_MS = 250;
  localparam int unsigned FAST_HALF_MS = 50;
  localparam int unsigned STARTUP_MIN_MS = 3000;
  localparam int unsigned CHG_ONTIME_MS = 30000;
  localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CLK_KHZ;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CLK_KHZ;
  localparam int unsigned STARTUP_MIN_CYC = STARTUP_MIN_MS * CLK_KHZ;
  localparam int unsigned CHG_ONTIME_CYC = CHG_ONTIME_MS * CLK_KHZ;
  localparam logic [15:0] FLICKER_SEED = 16'hace1;
  localparam logic [2:0] PORT_OFF = 3'h0;

  typedef enum logic [1:0] {
    CPST_SW_STOP = 2'h0,
    CPST_SW_RUN = 2'h1,
    CPST_SW_MEMRES = 2'h2
  } cpst_switch_e;

  typedef enum logic [1:0] {
    CPST_PORT_MASTER = 2'h0,
    CPST_PORT_SLAVE = 2'h1,
    CPST_PORT_P2P = 2'h2
  } cpst_port_e;

  typedef enum logic [18:0] {
    ST_BOOT = 19'h00001,
    ST_INIT1 = 19'h00002,
    ST_INIT2 = 19'h00004,
    ST_INIT3 = 19'h00008,
    ST_INIT4 = 19'h00010,
    ST_CARD_CHECK = 19'h00020,
    ST_CFG_LOAD = 19'h00040,
    ST_STOP = 19'h00080,
    ST_STARTUP = 19'h00100,
    ST_RUN = 19'h00200,
    ST_OVR_REQ = 19'h00400,
    ST_OVR_EXEC = 19'h00800,
    ST_FACTORY = 19'h01000,
    ST_FACTORY_DONE = 19'h02000,
    ST_FW_NEW = 19'h04000,
    ST_FW_UPD = 19'h08000,
    ST_FW_DONE = 19'h10000,
    ST_FW_ERR = 19'h20000,
    ST_SPARE = 19'h40000
  } cpst_state_e;

  typedef struct packed {
    logic run_indicator;
    logic stop_indicator;
    logic system_fault_indicator;
    logic force_indicator;
    logic card_access_indicator;
  } cpst_leds_s;

  typedef struct packed {
    logic link;
    logic activity;
    logic speed_100;
  } cpst_eth_s;

  typedef struct packed {
    logic master_en;
    logic slave_en;
    logic point_to_point_mode;
  } cpst_port_s;
endpackage : cpst_pkg
`default_nettype wire

// File: cpst_ctrl.sv
// Purpose: Operating state machine, CPU LEDs, Ethernet LEDs, serial port gate.
// Assumes: All inputs except the asynchronous reset_n synchronous to clk; pulses last one cycle.
// Notes: Battery flag state across power cycles is held outside this block.
`default_nettype none
module cpst_ctrl import cpst_pkg::*; #(
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = FAST_HALF_CYC,
  parameter int unsigned STARTUP_MIN = STARTUP_MIN_CYC,
  parameter int unsigned CHG_ONTIME = CHG_ONTIME_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire cpst_switch_e mode_switch,
  input wire logic battery_empty,
  input wire logic battery_full,
  input wire logic battery_flag_retained,
  input wire logic prev_cycle_qualified,
  input wire logic fw_loaded,
  input wire logic init_step,
  input wire logic card_check_done,
  input wire logic card_valid,
  input wire logic card_has_project,
  input wire logic card_has_firmware,
  input wire logic config_load_done,
  input wire logic reset_exec_done,
  input wire logic startup_block_done,
  input wire logic factory_reset_req,
  input wire logic factory_reset_done,
  input wire logic fw_update_start,
  input wire logic fw_update_done,
  input wire logic fw_update_error,
  input wire logic system_fault,
  input wire logic vars_forced,
  input wire logic card_access,
  input wire logic port_cfg_write,
  input wire cpst_port_e port_cfg_mode,
  input wire cpst_eth_s eth_status,
  output cpst_leds_s leds,
  output logic power_indicator,
  output logic eth_link_led,
  output logic eth_speed_led,
  output cpst_port_s port_en,
  output logic battery_error_flag,
  output logic ontime_qualified,
  output cpst_state_e op_state
);

  function automatic cpst_port_s port_decode(input cpst_port_e m);
    cpst_port_s p;
    p = '0;
    p.master_en = (m == CPST_PORT_MASTER);
    p.slave_en = (m == CPST_PORT_SLAVE);
    p.point_to_point_mode = (m == CPST_PORT_P2P);
    return p;
  endfunction

  cpst_state_e st_q, st_d;
  logic [1:0] blink_q;
  logic [31:0] div_cnt_q [2];
  logic [31:0] startup_cnt_q;
  logic [31:0] ontime_cnt_q;
  logic pwr_up_q;
  logic batt_err_q;
  logic qual_q;
  logic [15:0] lfsr_q;
  cpst_port_s port_q;
  cpst_leds_s leds_q, leds_d;
  logic slow_blink, fast_blink, startup_met;
  logic link_q, speed_q, pwr_q;

  assign slow_blink = blink_q[0];
  assign fast_blink = blink_q[1];
  assign startup_met = (startup_cnt_q >= STARTUP_MIN - 1);

  // Free-running square-wave dividers, index 0 slow, index 1 fast
  for (genvar i = 0; i < 2; i++) begin : g_div
    localparam int unsigned HALF = (i == 0) ? SLOW_HALF : FAST_HALF;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        div_cnt_q[i] <= '0;
        blink_q[i] <= 1'b0;
      end else if (div_cnt_q[i] >= HALF - 1) begin
        div_cnt_q[i] <= '0;
        blink_q[i] <= ~blink_q[i];
      end else begin
        div_cnt_q[i] <= div_cnt_q[i] + 32'h1;
      end
    end
  end

  // Battery state is evaluated one cycle after reset release, never in reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_up_q <= 1'b1;
      batt_err_q <= 1'b0;
    end else if (pwr_up_q) begin
      pwr_up_q <= 1'b0;
      batt_err_q <= battery_empty
        | (battery_flag_retained & ~prev_cycle_qualified);
    end
  end

  // Charged on-time qualification for clearing the flag next power-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ontime_cnt_q <= '0;
      qual_q <= 1'b0;
    end else if (!battery_full) begin
      ontime_cnt_q <= '0;
    end else if (!qual_q) begin
      if (ontime_cnt_q >= CHG_ONTIME - 1) begin
        qual_q <= 1'b1;
      end else begin
        ontime_cnt_q <= ontime_cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      startup_cnt_q <= '0;
    end else if (st_q != ST_STARTUP) begin
      startup_cnt_q <= '0;
    end else if (!startup_met) begin
      startup_cnt_q <= startup_cnt_q + 32'h1;
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_BOOT: if (fw_loaded) st_d = ST_INIT1;
      ST_INIT1: if (init_step) st_d = ST_INIT2;
      ST_INIT2: if (init_step) st_d = ST_INIT3;
      ST_INIT3: if (init_step) st_d = ST_INIT4;
      ST_INIT4: begin
        if (init_step) begin
          st_d = batt_err_q ? ST_OVR_EXEC : ST_CARD_CHECK;
        end
      end
      ST_CARD_CHECK: begin
        if (card_check_done) begin
          if (card_valid && card_has_firmware) begin
            st_d = ST_FW_NEW;
          end else if (card_valid && card_has_project) begin
            st_d = ST_CFG_LOAD;
          end else begin
            st_d = ST_STOP;
          end
        end
      end
      ST_CFG_LOAD: if (config_load_done) st_d = ST_STOP;
      ST_STOP: begin
        if (factory_reset_req) begin
          st_d = ST_FACTORY;
        end else if (mode_switch == CPST_SW_MEMRES) begin
          st_d = ST_OVR_REQ;
        end else if (mode_switch == CPST_SW_RUN) begin
          st_d = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (mode_switch != CPST_SW_RUN) begin
          st_d = ST_STOP;
        end else if (startup_block_done && startup_met) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: if (mode_switch != CPST_SW_RUN) st_d = ST_STOP;
      ST_OVR_REQ: begin
        if (mode_switch == CPST_SW_STOP) begin
          st_d = ST_OVR_EXEC;
        end else if (mode_switch == CPST_SW_RUN) begin
          st_d = ST_STOP;
        end
      end
      ST_OVR_EXEC: if (reset_exec_done) st_d = ST_CARD_CHECK;
      ST_FACTORY: if (factory_reset_done) st_d = ST_FACTORY_DONE;
      ST_FW_NEW: if (fw_update_start) st_d = ST_FW_UPD;
      ST_FW_UPD: begin
        if (fw_update_error) begin
          st_d = ST_FW_ERR;
        end else if (fw_update_done) begin
          st_d = ST_FW_DONE;
        end
      end
      // Factory reset and firmware end states wait for a power cycle
      ST_FACTORY_DONE, ST_FW_DONE, ST_FW_ERR: st_d = st_q;
      default: st_d = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_BOOT;
    end else begin
      st_q <= st_d;
    end
  end

  // Clearing wins over a configuration write during reset execution
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_q <= PORT_OFF;
    end else if (st_q == ST_OVR_EXEC) begin
      port_q <= PORT_OFF;
    end else if (port_cfg_write && port_cfg_mode != 2'h3) begin
      port_q <= port_decode(port_cfg_mode);
    end
  end

  always_comb begin
    leds_d = '0;
    case (st_q)
      ST_BOOT: leds_d = {1'b1, fast_blink, 3'b111};
      ST_INIT1: leds_d = 5'b11111;
      ST_INIT2: leds_d = 5'b11110;
      ST_INIT3: leds_d = 5'b11100;
      ST_INIT4: leds_d = 5'b01100;
      ST_CARD_CHECK, ST_STOP: begin
        leds_d = {1'b0, 1'b1, system_fault, vars_forced, card_access};
      end
      ST_STARTUP: begin
        leds_d = {slow_blink, 1'b1, system_fault, vars_forced,
                  card_access};
      end
      ST_RUN: begin
        leds_d = {~system_fault, 1'b0, system_fault, vars_forced,
                  card_access};
      end
      ST_CFG_LOAD: leds_d = {1'b0, fast_blink, 3'b000};
      ST_OVR_REQ: begin
        leds_d = {1'b0, slow_blink, system_fault, vars_forced,
                  card_access};
      end
      ST_OVR_EXEC: begin
        leds_d = {1'b0, fast_blink, system_fault, vars_forced,
                  card_access};
      end
      ST_FACTORY: leds_d = 5'b11000;
      ST_FACTORY_DONE: leds_d = 5'b01111;
      ST_FW_NEW: leds_d = {2'b01, slow_blink, ~slow_blink, 1'b1};
      ST_FW_UPD: leds_d = {2'b00, slow_blink, ~slow_blink, 1'b1};
      ST_FW_DONE: leds_d = 5'b01111;
      ST_FW_ERR: leds_d = {1'b0, {4{fast_blink}}};
      default: leds_d = '0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      leds_q <= '0;
    end else begin
      leds_q <= leds_d;
    end
  end

  // Pseudo-random flicker so traffic looks irregular, not like a blink
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lfsr_q <= FLICKER_SEED;
      link_q <= 1'b0;
      speed_q <= 1'b0;
      pwr_q <= 1'b0;
    end else begin
      if (div_cnt_q[1] == 32'h0) begin
        lfsr_q <= {lfsr_q[14:0],
                   lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
      link_q <= eth_status.link
        & ~(eth_status.activity & lfsr_q[0]);
      speed_q <= eth_status.speed_100;
      pwr_q <= 1'b1;
    end
  end

  assign leds = leds_q;
  assign power_indicator = pwr_q;
  assign eth_link_led = link_q;
  assign eth_speed_led = speed_q;
  assign port_en = port_q;
  assign battery_error_flag = batt_err_q;
  assign ontime_qualified = qual_q;
  assign op_state = st_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_port_off_in_reset;
    st_q == ST_OVR_EXEC |=> port_q == PORT_OFF;
  endproperty
  a_port_off_in_reset: assert property (p_port_off_in_reset)
    else $error("serial port active after overall reset");

  property p_port_single;
    $onehot0(port_q);
  endproperty
  a_port_single: assert property (p_port_single)
    else $error("more than one serial port function active");

  property p_batt_forces_reset;
    st_q == ST_INIT4 && init_step && batt_err_q |=> st_q == ST_OVR_EXEC;
  endproperty
  a_batt_forces_reset: assert property (p_batt_forces_reset)
    else $error("battery flag did not force overall reset");

  property p_run_via_startup;
    st_q == ST_RUN && $past(st_q) != ST_RUN |-> $past(st_q) == ST_STARTUP;
  endproperty
  a_run_via_startup: assert property (p_run_via_startup)
    else $error("RUN entered without start-up");

  property p_startup_min;
    st_q == ST_STARTUP && st_d == ST_RUN |-> startup_cnt_q >= STARTUP_MIN - 1;
  endproperty
  a_startup_min: assert property (p_startup_min)
    else $error("start-up shorter than minimum");

  property p_stop_leds;
    st_q == ST_STOP |=> !leds.run_indicator && leds.stop_indicator;
  endproperty
  a_stop_leds: assert property (p_stop_leds)
    else $error("wrong LEDs in STOP");

  property p_run_leds;
    st_q == ST_RUN && !system_fault |=> leds.run_indicator
      && !leds.stop_indicator && !leds.system_fault_indicator;
  endproperty
  a_run_leds: assert property (p_run_leds)
    else $error("wrong LEDs in RUN");

  property p_cfg_leds;
    st_q == ST_CFG_LOAD |=> leds[2:0] == 3'h0 && !leds.run_indicator;
  endproperty
  a_cfg_leds: assert property (p_cfg_leds)
    else $error("wrong LEDs during configuration load");

  property p_fw_alternate;
    st_q == ST_FW_UPD |=> leds.system_fault_indicator != leds.force_indicator
      && !leds.stop_indicator;
  endproperty
  a_fw_alternate: assert property (p_fw_alternate)
    else $error("firmware LEDs not alternating");

  property p_speed;
    1'b1 |=> eth_speed_led == $past(eth_status.speed_100);
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed LED wrong");

  c_run: cover property (st_q == ST_STARTUP ##1 st_q == ST_RUN);
  c_ovr: cover property (st_q == ST_OVR_REQ ##1 st_q == ST_OVR_EXEC);
  c_fw_err: cover property (st_q == ST_FW_UPD ##1 st_q == ST_FW_ERR);
endmodule // cpst_ctrl
`default_nettype wire

// File: cpst_tb.sv
// Purpose: Self-checking bench for the CPU state and LED indicator.
// Assumes: Short divider and count parameters; 20 MHz clock.
// Notes: Event inputs are pulsed through one vector to keep tasks small.
`default_nettype none
module testbench import cpst_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SH = 4;
  localparam int unsigned FH = 2;
  localparam int unsigned SM = 20;
  localparam int unsigned BO = 30;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] ev = 12'h000;
  logic b_empty = 1'b0, b_full = 1'b0, b_ret = 1'b0, b_prev = 1'b0;
  logic c_valid = 1'b0, c_proj = 1'b0, c_fw = 1'b0;
  logic fault = 1'b0, forced = 1'b0, c_acc = 1'b0;
  cpst_switch_e sw = CPST_SW_STOP;
  cpst_port_e pmode = CPST_PORT_MASTER;
  cpst_eth_s eth = 3'h0;
  cpst_leds_s leds;
  cpst_port_s port_en;
  cpst_state_e op_state;
  logic pwr, link_led, speed_led, batt_err, ontime;
  int fail_count = 0;
  int n_compared = 0;
  always #25 clk = ~clk;
  cpst_ctrl #(.SLOW_HALF(SH), .FAST_HALF(FH), .STARTUP_MIN(SM),
    .CHG_ONTIME(BO)) dut_u (.clk(clk), .reset_n(reset_n),
    .mode_switch(sw), .battery_empty(b_empty), .battery_full(b_full),
    .battery_flag_retained(b_ret), .prev_cycle_qualified(b_prev),
    .fw_loaded(ev[0]), .init_step(ev[1]), .card_check_done(ev[2]),
    .card_valid(c_valid), .card_has_project(c_proj),
    .card_has_firmware(c_fw), .config_load_done(ev[3]),
    .reset_exec_done(ev[4]), .startup_block_done(ev[5]),
    .factory_reset_req(ev[6]), .factory_reset_done(ev[7]),
    .fw_update_start(ev[8]), .fw_update_done(ev[9]),
    .fw_update_error(ev[10]), .system_fault(fault),
    .vars_forced(forced), .card_access(c_acc),
    .port_cfg_write(ev[11]), .port_cfg_mode(pmode), .eth_status(eth),
    .leds(leds), .power_indicator(pwr), .eth_link_led(link_led),
    .eth_speed_led(speed_led), .port_en(port_en),
    .battery_error_flag(batt_err), .ontime_qualified(ontime),
    .op_state(op_state));
  task automatic chk(input logic [18:0] g, input logic [18:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_led(input logic [4:0] e);
    chk({14'h0, leds}, {14'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  // State moves on the taking edge, the LEDs one edge later
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    cyc(1);
    ev[i] = 1'b0;
    cyc(1);
  endtask
  task automatic half(input int b, input int e);
    logic p;
    int n;
    p = leds[b];
    n = 0;
    while (leds[b] === p && n < 40) begin
      cyc(1);
      n++;
    end
    p = leds[b];
    n = 0;
    while (leds[b] === p && n < 40) begin
      cyc(1);
      n++;
    end
    chk(19'(n), 19'(e));
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    cyc(3);
    reset_n = 1'b1;
    cyc(2);
  endtask
  task automatic boot(input logic v, input logic p, input logic f);
    do_reset();
    pulse(0);
    repeat (4) pulse(1);
    c_valid = v;
    c_proj = p;
    c_fw = f;
    if (op_state === ST_CARD_CHECK) pulse(2);
  endtask
  task automatic t_boot();
    do_reset();
    chk({18'h0, pwr}, 19'h1);
    chk_led(5'h17 | {1'b0, leds.stop_indicator, 3'h0});
    half(3, FH);
    chk(19'(port_en), 19'h0);
    pulse(0);
    chk_led(5'h1f);
    pulse(1);
    chk_led(5'h1e);
    pulse(1);
    chk_led(5'h1c);
    pulse(1);
    chk_led(5'h0c);
    pulse(1);
    chk(op_state, ST_CARD_CHECK);
    pulse(2);
    chk(op_state, ST_STOP);
    chk_led(5'h08);
    fault = 1'b1;
    forced = 1'b1;
    c_acc = 1'b1;
    cyc(2);
    chk_led(5'h0f);
    fault = 1'b0;
    forced = 1'b0;
    c_acc = 1'b0;
    $display("test boot done");
  endtask
  task automatic t_port();
    for (int m = 0; m < 3; m++) begin
      pmode = cpst_port_e'(m);
      pulse(11);
      chk(19'(port_en), 19'(3'h4 >> m));
    end
    pmode = cpst_port_e'(2'h3);
    pulse(11);
    chk(19'(port_en), 19'h1);
    $display("test port done");
  endtask
  task automatic t_run();
    int n, tg;
    logic p;
    sw = CPST_SW_RUN;
    cyc(1);
    chk(op_state, ST_STARTUP);
    ev[5] = 1'b1;
    n = 0;
    tg = 0;
    p = leds.run_indicator;
    while (op_state === ST_STARTUP && n < 60) begin
      cyc(1);
      n++;
      if (n == 10) chk({18'h0, leds.stop_indicator}, 19'h1);
      if (leds.run_indicator !== p) tg++;
      p = leds.run_indicator;
    end
    ev[5] = 1'b0;
    chk({18'h0, n >= SM && n <= SM + 4}, 19'h1);
    chk({18'h0, tg >= 3}, 19'h1);
    cyc(1);
    chk(op_state, ST_RUN);
    chk_led(5'h10);
    sw = CPST_SW_STOP;
    cyc(2);
    chk(op_state, ST_STOP);
    $display("test run done");
  endtask
  task automatic t_ovr();
    sw = CPST_SW_MEMRES;
    cyc(2);
    chk(op_state, ST_OVR_REQ);
    chk({18'h0, leds.run_indicator}, 19'h0);
    half(3, SH);
    sw = CPST_SW_STOP;
    cyc(2);
    chk(op_state, ST_OVR_EXEC);
    chk(19'(port_en), 19'h0);
    half(3, FH);
    c_valid = 1'b1;
    c_proj = 1'b1;
    pulse(4);
    chk(op_state, ST_CARD_CHECK);
    fault = 1'b1;
    pulse(2);
    chk(op_state, ST_CFG_LOAD);
    chk({16'h0, leds[2:0]}, 19'h0);
    half(3, FH);
    fault = 1'b0;
    pulse(3);
    chk(op_state, ST_STOP);
    pulse(6);
    chk_led(5'h18);
    pulse(7);
    cyc(5);
    chk_led(5'h0f);
    $display("test overall reset done");
  endtask
  task automatic t_fw();
    boot(1'b1, 1'b0, 1'b1);
    chk(op_state, ST_FW_NEW);
    chk({17'h0, leds.run_indicator, leds.card_access_indicator}, 19'h1);
    chk({18'h0, leds.stop_indicator}, 19'h1);
    chk({18'h0, leds.system_fault_indicator ^ leds.force_indicator},
      19'h1);
    half(2, SH);
    pulse(8);
    chk({18'h0, leds.stop_indicator}, 19'h0);
    ev[9] = 1'b1;
    pulse(10);
    ev[9] = 1'b0;
    chk(op_state, ST_FW_ERR);
    half(1, FH);
    boot(1'b1, 1'b0, 1'b1);
    pulse(8);
    pulse(9);
    chk_led(5'h0f);
    $display("test fw done");
  endtask
  task automatic t_battery();
    b_empty = 1'b1;
    boot(1'b0, 1'b0, 1'b0);
    chk({18'h0, batt_err}, 19'h1);
    chk(op_state, ST_OVR_EXEC);
    pulse(4);
    chk(op_state, ST_CARD_CHECK);
    b_empty = 1'b0;
    b_ret = 1'b1;
    do_reset();
    chk({18'h0, batt_err}, 19'h1);
    b_prev = 1'b1;
    do_reset();
    chk({18'h0, batt_err}, 19'h0);
    b_full = 1'b1;
    cyc(BO - 5);
    chk({18'h0, ontime}, 19'h0);
    cyc(8);
    chk({18'h0, ontime}, 19'h1);
    $display("test battery done");
  endtask
  task automatic t_eth();
    int lo;
    eth = 3'h5;
    cyc(2);
    chk({17'h0, link_led, speed_led}, 19'h3);
    eth = 3'h6;
    lo = 0;
    repeat (60) begin
      cyc(1);
      if (link_led === 1'b0) lo++;
    end
    chk({18'h0, lo > 0 && lo < 60}, 19'h1);
    eth = 3'h0;
    cyc(2);
    chk({17'h0, link_led, speed_led}, 19'h0);
    $display("test eth done");
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    fail_count++;
    close_out();
  end
  initial begin
    #1;
    t_boot();
    t_port();
    t_run();
    t_ovr();
    t_fw();
    t_battery();
    t_eth();
    close_out();
  end
endmodule // testbench
`default_nettype wire
